// ### logic/epc_ahb_slave.sv
// ahb-lite slave front end: captures the address phase, one wait state
`timescale 1ns/1ps
`include "epc_consts.svh"
module epc_ahb_slave (
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             hsel_i,
	input  wire logic [31:0]      haddr_i,
	input  wire logic [1:0]       htrans_i,
	input  wire logic             hwrite_i,
	input  wire logic [3:0]       hprot_i,
	input  wire logic             hready_i,
	output logic                  hreadyout_o,
	output epc_pkg::epc_acc_s     acc_o
);

	epc_pkg::epc_ahb_s q;
	epc_pkg::epc_ahb_s d;
	logic              take;

	// the wait state lets the register file answer from flops
	always_comb begin
		d    = q;
		take = hsel_i & htrans_i[`EPC_HTRANS_ACT] & hready_i;
		case (q.phase)
			epc_pkg::EPC_PH_IDLE: begin
				d.ready = 1'b1;
				if (take) begin
					d.phase = epc_pkg::EPC_PH_DATA;
					d.write = hwrite_i;
					d.priv  = hprot_i[`EPC_HPROT_PRIV];
					d.addr  = haddr_i[`EPC_ADDR_W-1:0];
					d.ready = 1'b0;
				end
			end
			epc_pkg::EPC_PH_DATA: begin
				d.phase = epc_pkg::EPC_PH_IDLE;
				d.ready = 1'b1;
			end
			default: begin
				d.phase = epc_pkg::EPC_PH_IDLE;
				d.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{phase: epc_pkg::EPC_PH_IDLE, write: 1'b0, priv: 1'b0,
			       addr: '0, ready: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign hreadyout_o = q.ready;
	// one driver for the whole carrier struct
	assign acc_o = '{valid: (q.phase == epc_pkg::EPC_PH_DATA),
	                 write: q.write,
	                 priv:  q.priv,
	                 addr:  q.addr};

endmodule

// ### logic/epc_consts.svh
// constants for the exception pend control block
// Operation
// - nmi set-pending bit reads pending state; writing one sets it, zero ignored
// - core clears nmi pending automatically when it enters the nmi handler
// - in the nmi handler the bit reads one only after a new nmi assertion; the code also sets it there on a write of one
// - deferred-service set-pending bit reads pending state; writing one sets it
// - only a software write of one sets deferred-service pending, no hardware event
// - writing one to deferred-service clear bit removes pending; clear bit reads unknown
// - tick set-pending bit reads pending state; writing one sets it, zero ignored
// - writing one to tick clear bit removes tick pending; clear bit reads unknown
// - debug release indicator reads one when leaving halt will take an interrupt
// - debug release indicator reads zero whenever the core is not in debug mode
// - interrupt-pending flag shows any external interrupt pending, not nmi or faults
// - only privileged accesses reach the control and state register
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH

`define EPC_ADDR_W         12
`define EPC_DATA_W         32
`define EPC_OFF_ICS        12'h000
`define EPC_OFF_EVT_STAT   12'h004
`define EPC_OFF_EVT_CLR    12'h008
`define EPC_OFF_EVT_EN     12'h00C

`define EPC_BIT_NMI_SET    31
`define EPC_BIT_DSV_SET    28
`define EPC_BIT_DSV_CLR    27
`define EPC_BIT_TICK_SET   26
`define EPC_BIT_TICK_CLR   25
`define EPC_BIT_DBG_REL    23
`define EPC_BIT_IRQ_PEND   22

`define EPC_EXT_IRQS       30
`define EPC_EVT_W          4
`define EPC_EVT_NMI        0
`define EPC_EVT_DSV        1
`define EPC_EVT_TICK       2
`define EPC_EVT_DENIED     3

`define EPC_SY_NMI         0
`define EPC_SY_HALT        1
`define EPC_SY_REL         2
`define EPC_SY_EXT         3
`define EPC_SYNC_W         33

`define EPC_HTRANS_ACT     1
`define EPC_HPROT_PRIV     1
`define EPC_HRESP_OKAY     1'h0
`define EPC_ZERO_WORD      32'h0000_0000
`define EPC_ZERO_EVT       4'h0

`endif

// ### logic/epc_pkg.sv
// types shared by the exception pend control block
`include "epc_consts.svh"
package epc_pkg;

	typedef enum logic {
		EPC_PH_IDLE = 1'b0,
		EPC_PH_DATA = 1'b1
	} epc_phase_e;

	typedef struct packed {
		logic                    valid;
		logic                    write;
		logic                    priv;
		logic [`EPC_ADDR_W-1:0]  addr;
	} epc_acc_s;

	typedef struct packed {
		epc_phase_e              phase;
		logic                    write;
		logic                    priv;
		logic [`EPC_ADDR_W-1:0]  addr;
		logic                    ready;
	} epc_ahb_s;

	typedef struct packed {
		logic                    nmi_pend;
		logic                    nmi_prev;
		logic                    dsv_pend;
		logic                    tick_pend;
		logic [`EPC_EVT_W-1:0]   evt_status;
		logic [`EPC_EVT_W-1:0]   evt_enable;
		logic                    irq;
		logic [`EPC_DATA_W-1:0]  rdata;
		logic                    hresp;
	} epc_state_s;

endpackage

// ### logic/epc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module epc_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} epc_sync_s;

	epc_sync_s q;
	epc_sync_s d;

	// the meta stage feeds only the second stage
	always_comb begin
		d      = q;
		d.meta = async_i;
		d.sync = q.meta;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.sync;

endmodule

// ### logic/epc_top.sv
// exception set/clear pending control and status with ahb-lite registers
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "epc_consts.svh"
module epc_top (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     hsel_i,
	input  wire logic [31:0]              haddr_i,
	input  wire logic [1:0]               htrans_i,
	input  wire logic                     hwrite_i,
	input  wire logic [2:0]               hsize_i,
	input  wire logic [3:0]               hprot_i,
	input  wire logic [31:0]              hwdata_i,
	input  wire logic                     hready_i,
	output logic      [31:0]              hrdata_o,
	output logic                          hreadyout_o,
	output logic                          hresp_o,
	input  wire logic                     nmi_i,
	input  wire logic [`EPC_EXT_IRQS-1:0] ext_irq_i,
	input  wire logic                     debug_halted_i,
	input  wire logic                     debug_release_irq_i,
	input  wire logic                     nmi_entry_i,
	input  wire logic                     dsv_entry_i,
	input  wire logic                     tick_entry_i,
	input  wire logic                     tick_event_i,
	output logic                          nmi_pending_o,
	output logic                          dsv_pending_o,
	output logic                          tick_pending_o,
	output logic                          irq_o
);

	epc_pkg::epc_state_s        q;
	epc_pkg::epc_state_s        d;
	epc_pkg::epc_acc_s          acc;
	logic [`EPC_SYNC_W-1:0]     sy;
	logic                       wr_ok;
	logic                       rd_ok;
	logic                       denied;
	logic                       ics_wr;
	logic                       nmi_set_wr;
	logic                       dsv_set_wr;
	logic                       dsv_clr_wr;
	logic                       tick_set_wr;
	logic                       tick_clr_wr;
	logic                       nmi_rise;
	logic                       dbg_rel;
	logic                       ext_pend;
	logic [`EPC_EVT_W-1:0]      evt_new;
	logic [`EPC_DATA_W-1:0]     ics_rd;

	function automatic logic epc_hit(input logic [`EPC_ADDR_W-1:0] a,
	                                 input logic [`EPC_ADDR_W-1:0] off);
		return a == off;
	endfunction

	epc_sync #(
		.W (`EPC_SYNC_W)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.async_i ({ext_irq_i, debug_release_irq_i, debug_halted_i, nmi_i}),
		.sync_o  (sy)
	);

	epc_ahb_slave u_ahb (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hprot_i     (hprot_i),
		.hready_i    (hready_i),
		.hreadyout_o (hreadyout_o),
		.acc_o       (acc)
	);

	always_comb begin
		d = q;

		// unprivileged accesses complete with okay but touch only the denied event bit
		wr_ok  = acc.valid & acc.write & acc.priv;
		rd_ok  = acc.valid & ~acc.write & acc.priv;
		denied = acc.valid & ~acc.priv;

		ics_wr      = wr_ok & epc_hit(acc.addr, `EPC_OFF_ICS);
		nmi_set_wr  = ics_wr & hwdata_i[`EPC_BIT_NMI_SET];
		dsv_set_wr  = ics_wr & hwdata_i[`EPC_BIT_DSV_SET];
		dsv_clr_wr  = ics_wr & hwdata_i[`EPC_BIT_DSV_CLR];
		tick_set_wr = ics_wr & hwdata_i[`EPC_BIT_TICK_SET];
		tick_clr_wr = ics_wr & hwdata_i[`EPC_BIT_TICK_CLR];

		// only a fresh edge of the pin, or a write of one, re-arms nmi after handler entry
		nmi_rise   = sy[`EPC_SY_NMI] & ~q.nmi_prev;
		d.nmi_prev = sy[`EPC_SY_NMI];

		dbg_rel  = sy[`EPC_SY_HALT] & sy[`EPC_SY_REL];
		ext_pend = |sy[`EPC_SY_EXT +: `EPC_EXT_IRQS];

		// entry clears; a set in the same cycle wins
		if (nmi_entry_i) begin
			d.nmi_pend = 1'b0;
		end
		if (nmi_set_wr | nmi_rise) begin
			d.nmi_pend = 1'b1;
		end

		// simultaneous set and clear resolves to set
		if (dsv_entry_i | dsv_clr_wr) begin
			d.dsv_pend = 1'b0;
		end
		if (dsv_set_wr) begin
			d.dsv_pend = 1'b1;
		end

		if (tick_entry_i | tick_clr_wr) begin
			d.tick_pend = 1'b0;
		end
		if (tick_set_wr | tick_event_i) begin
			d.tick_pend = 1'b1;
		end

		evt_new = `EPC_ZERO_EVT;
		evt_new[`EPC_EVT_NMI]    = d.nmi_pend & ~q.nmi_pend;
		evt_new[`EPC_EVT_DSV]    = d.dsv_pend & ~q.dsv_pend;
		evt_new[`EPC_EVT_TICK]   = d.tick_pend & ~q.tick_pend;
		evt_new[`EPC_EVT_DENIED] = denied;

		if (wr_ok & epc_hit(acc.addr, `EPC_OFF_EVT_CLR)) begin
			d.evt_status = q.evt_status & ~hwdata_i[`EPC_EVT_W-1:0];
		end
		// new events win over a clear in the same cycle
		d.evt_status = d.evt_status | evt_new;

		if (wr_ok & epc_hit(acc.addr, `EPC_OFF_EVT_EN)) begin
			d.evt_enable = hwdata_i[`EPC_EVT_W-1:0];
		end
		d.irq = |(d.evt_status & d.evt_enable);

		// clear bits are write only and read back as zero here
		ics_rd = `EPC_ZERO_WORD;
		ics_rd[`EPC_BIT_NMI_SET]  = q.nmi_pend;
		ics_rd[`EPC_BIT_DSV_SET]  = q.dsv_pend;
		ics_rd[`EPC_BIT_TICK_SET] = q.tick_pend;
		ics_rd[`EPC_BIT_DBG_REL]  = dbg_rel;
		ics_rd[`EPC_BIT_IRQ_PEND] = ext_pend;

		d.rdata = `EPC_ZERO_WORD;
		if (rd_ok) begin
			case (acc.addr)
				`EPC_OFF_ICS:      d.rdata = ics_rd;
				`EPC_OFF_EVT_STAT: d.rdata[`EPC_EVT_W-1:0] = q.evt_status;
				`EPC_OFF_EVT_EN:   d.rdata[`EPC_EVT_W-1:0] = q.evt_enable;
				default:           d.rdata = `EPC_ZERO_WORD;
			endcase
		end
		d.hresp = `EPC_HRESP_OKAY;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hrdata_o       = q.rdata;
	assign hresp_o        = q.hresp;
	assign nmi_pending_o  = q.nmi_pend;
	assign dsv_pending_o  = q.dsv_pend;
	assign tick_pending_o = q.tick_pend;
	assign irq_o          = q.irq;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_nmi_write_set: assert property (nmi_set_wr |=> nmi_pending_o ##1 1'b1)
		else $error("nmi write of one did not set pending");

	a_nmi_entry_clr: assert property (
		nmi_entry_i && !nmi_set_wr && !nmi_rise |=> !nmi_pending_o)
		else $error("nmi pending survived handler entry");

	a_nmi_rearm_cause: assert property (
		$rose(nmi_pending_o) |-> $past(nmi_rise || nmi_set_wr))
		else $error("nmi pending rose without a new assertion or write");

	a_dsv_write_set: assert property (
		dsv_set_wr |=> dsv_pending_o)
		else $error("deferred-service write of one did not set pending");

	a_dsv_sw_only: assert property (
		$rose(dsv_pending_o) |-> $past(dsv_set_wr))
		else $error("deferred-service pending set by hardware");

	a_dsv_clear: assert property (
		dsv_clr_wr && !dsv_set_wr |=> !dsv_pending_o)
		else $error("deferred-service clear had no effect");

	a_tick_set: assert property (
		tick_set_wr |=> tick_pending_o ##1 (tick_pending_o || $past(tick_entry_i || tick_clr_wr)))
		else $error("tick write of one did not set pending");

	a_tick_clear: assert property (
		tick_clr_wr && !tick_set_wr && !tick_event_i |=> !tick_pending_o)
		else $error("tick clear had no effect");

	a_dbg_rel_read: assert property (
		rd_ok && acc.addr == `EPC_OFF_ICS |=>
		hrdata_o[`EPC_BIT_DBG_REL] == $past(sy[`EPC_SY_HALT] && sy[`EPC_SY_REL]) && hreadyout_o)
		else $error("debug release indicator read wrong");

	a_dbg_zero_run: assert property (
		rd_ok && !sy[`EPC_SY_HALT] |=> !hrdata_o[`EPC_BIT_DBG_REL])
		else $error("debug release indicator set outside debug");

	a_irq_pend_read: assert property (
		rd_ok && acc.addr == `EPC_OFF_ICS |=>
		hrdata_o[`EPC_BIT_IRQ_PEND] == $past(|sy[`EPC_SY_EXT +: `EPC_EXT_IRQS]))
		else $error("interrupt pending flag read wrong");

	a_unpriv_blocked: assert property (
		acc.valid && !acc.priv |=> hrdata_o == `EPC_ZERO_WORD &&
		(dsv_pending_o == $past(dsv_pending_o) || $past(dsv_entry_i)))
		else $error("unprivileged access was honoured");

endmodule

// ### verif/tb_top.sv
// self-checking bench for the exception pend control block
`timescale 1ns/1ps
`include "epc_consts.svh"
module tb_top;
	localparam logic [31:0] A_ICS  = {20'h00000, `EPC_OFF_ICS};
	localparam logic [31:0] A_STAT = {20'h00000, `EPC_OFF_EVT_STAT};
	localparam logic [31:0] A_CLR  = {20'h00000, `EPC_OFF_EVT_CLR};
	localparam logic [31:0] A_EN   = {20'h00000, `EPC_OFF_EVT_EN};
	localparam logic [31:0] A_NONE = 32'h0000_0010;
	localparam logic [31:0] B_NMI  = 32'h8000_0000;
	localparam logic [31:0] B_DSV  = 32'h1000_0000;
	localparam logic [31:0] B_DCL  = 32'h0800_0000;
	localparam logic [31:0] B_TCK  = 32'h0400_0000;
	localparam logic [31:0] B_TCL  = 32'h0200_0000;
	localparam logic [31:0] B_DBG  = 32'h0080_0000;
	localparam logic [31:0] B_IRQ  = 32'h0040_0000;

	logic                     mclk_i;
	logic                     rst_i;
	logic                     hsel;
	logic [31:0]              haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [3:0]               hprot;
	logic [31:0]              hwdata;
	logic [31:0]              hrdata;
	logic                     hready;
	logic                     hresp;
	logic                     nmi;
	logic [`EPC_EXT_IRQS-1:0] ext_irq;
	logic                     dbg_halt;
	logic                     dbg_rel;
	logic [3:0]               strb;
	logic                     nmi_pend;
	logic                     dsv_pend;
	logic                     tick_pend;
	logic                     irq;
	int                       err_total;
	int                       compares;

	epc_top uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hprot_i(hprot), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.nmi_i(nmi), .ext_irq_i(ext_irq), .debug_halted_i(dbg_halt),
		.debug_release_irq_i(dbg_rel), .nmi_entry_i(strb[0]), .dsv_entry_i(strb[1]),
		.tick_entry_i(strb[2]), .tick_event_i(strb[3]), .nmi_pending_o(nmi_pend),
		.dsv_pending_o(dsv_pend), .tick_pending_o(tick_pend), .irq_o(irq)
	);

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// sampled at the falling edge: registered outputs are stable until the next rise
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
	                   input logic pv, output logic [31:0] rd);
		logic rdy;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hprot  <= pv ? 4'h3 : 4'h1;
		do begin
			@(negedge mclk_i);
			rdy = hready;
			@(posedge mclk_i);
		end while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge mclk_i);
			rdy = hready;
			rd  = hrdata;
			chk("hresp", {31'h0, hresp}, {31'h0, `EPC_HRESP_OKAY});
			@(posedge mclk_i);
		end while (rdy !== 1'b1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic pv = 1'b1);
		logic [31:0] dummy;
		bus(1'b1, a, d, pv, dummy);
	endtask

	task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp,
	                  input logic pv = 1'b1);
		logic [31:0] v;
		bus(1'b0, a, 32'h0000_0000, pv, v);
		chk(nm, v, exp);
	endtask

	// order of exp: irq, tick, deferred service, nmi
	task automatic outs(input logic [3:0] exp);
		@(negedge mclk_i);
		chk("outputs", {28'h0, irq, tick_pend, dsv_pend, nmi_pend}, {28'h0, exp});
		@(posedge mclk_i);
	endtask

	task automatic pulse(input logic [3:0] v);
		strb <= v;
		@(posedge mclk_i);
		strb <= 4'h0;
		@(posedge mclk_i);
	endtask

	initial begin
		#80000;
		err_total++;
		wrap_up();
	end

	initial begin
		err_total = 0;
		compares  = 0;
		rst_i = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hprot = 4'h3; hwdata = 32'h0; nmi = 1'b0; ext_irq = '0; dbg_halt = 1'b0;
		dbg_rel = 1'b0; strb = 4'h0;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		rc("ics reset", A_ICS, 32'h0);
		rc("stat reset", A_STAT, 32'h0);
		rc("en reset", A_EN, 32'h0);
		rc("clr reads", A_CLR, 32'h0);
		wr(A_NONE, 32'hFFFF_FFFF);
		rc("unmapped", A_NONE, 32'h0);
		outs(4'h0);
		$display("test reset done");
		wr(A_ICS, 32'h0);
		outs(4'h0);
		wr(A_ICS, B_NMI);
		rc("nmi set", A_ICS, B_NMI);
		pulse(4'h1);
		outs(4'h0);
		rc("nmi in handler", A_ICS, 32'h0);
		nmi <= 1'b1;
		repeat (6) @(posedge mclk_i);
		rc("nmi reasserted", A_ICS, B_NMI);
		pulse(4'h1);
		rc("nmi held no rearm", A_ICS, 32'h0);
		nmi <= 1'b0;
		$display("test nmi done");
		pulse(4'h8);
		outs(4'h4);
		wr(A_ICS, B_TCL);
		outs(4'h0);
		wr(A_ICS, B_DSV); // set and clear never together
		rc("dsv set", A_ICS, B_DSV);
		wr(A_ICS, 32'h0);
		outs(4'h2);
		wr(A_ICS, B_DCL);
		rc("dsv clear", A_ICS, 32'h0);
		wr(A_ICS, B_TCK);
		rc("tick set", A_ICS, B_TCK);
		outs(4'h4);
		wr(A_ICS, B_TCL);
		rc("tick clear", A_ICS, 32'h0);
		$display("test set clear done");
		dbg_halt <= 1'b1;
		dbg_rel  <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rc("dbg release", A_ICS, B_DBG);
		dbg_halt <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rc("dbg not halted", A_ICS, 32'h0);
		dbg_halt <= 1'b1;
		dbg_rel  <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rc("dbg no irq", A_ICS, 32'h0);
		dbg_halt <= 1'b0;
		ext_irq  <= 30'h2000_0001;
		repeat (4) @(posedge mclk_i);
		rc("ext pending", A_ICS, B_IRQ);
		ext_irq <= '0;
		nmi     <= 1'b1;
		repeat (6) @(posedge mclk_i);
		rc("nmi not ext", A_ICS, B_NMI);
		pulse(4'h1);
		nmi <= 1'b0;
		$display("test status done");
		wr(A_ICS, B_DSV, 1'b0);
		outs(4'h0);
		wr(A_ICS, B_TCK);
		rc("unpriv read", A_ICS, 32'h0, 1'b0);
		wr(A_ICS, B_TCL);
		$display("test privilege done");
		rc("events sticky", A_STAT, 32'h0000_000F);
		outs(4'h0);
		wr(A_EN, 32'h0000_0004);
		rc("en rw", A_EN, 32'h0000_0004);
		outs(4'h8);
		wr(A_CLR, 32'h0000_0004);
		outs(4'h0);
		rc("events cleared", A_STAT, 32'h0000_000B);
		pulse(4'h8);
		outs(4'hC);
		wr(A_EN, 32'h0);
		outs(4'h4);
		wr(A_CLR, 32'h0000_000F);
		rc("events empty", A_STAT, 32'h0);
		$display("test interrupt done");
		// tick is still pending here: a mid-run reset must drop it
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		outs(4'h0);
		rc("ics after reset", A_ICS, 32'h0);
		rc("stat after reset", A_STAT, 32'h0);
		rc("en after reset", A_EN, 32'h0);
		$display("test mid reset done");
		wrap_up();
	end
endmodule
